//--- mesf_pkg.sv
/*
 * Shared constants of the metering event status flag bank: register
 * addresses, flag bit positions, reset values and sequence states.
 * Assumes a host that reaches the two status words by their printed address.
 */
package mesf_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [15:0] ADDR_STATUS_ONE = 16'h0401;
    localparam logic [15:0] ADDR_STATUS_TWO = 16'h0402;

    // ************************************************************
    // Bit positions, word one
    // ************************************************************
    localparam int BIT_ENERGY_READY   = 0;
    localparam int BIT_PHASE_SIGN_LO  = 1;   // A, B, C at 1, 2, 3
    localparam int BIT_PULSE_SIGN_LO  = 4;   // Outputs one, two at 4, 5
    localparam int BIT_PULSE_DONE_LO  = 6;   // Outputs one, two at 6, 7
    localparam int BIT_RMS_READY      = 8;
    localparam int BIT_PF_READY       = 9;
    localparam int BIT_SUM_MISMATCH   = 10;
    localparam int BIT_ACTIVE_NOLOAD  = 11;
    localparam int BIT_APPAR_NOLOAD   = 12;
    localparam int BIT_CHECKSUM_CHG   = 13;
    localparam int BIT_FAULT          = 14;
    localparam int BIT_PHASE_ORDER    = 15;
    localparam int BIT_TIMEOUT_LO     = 16;  // A, B, C at 16, 17, 18
    localparam int FLAGS_ONE_W        = 19;

    // ************************************************************
    // Bit positions, word two
    // ************************************************************
    localparam int BIT_AC_SWELL       = 30;
    localparam int BIT_RESERVED_TWO   = 31;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [18:0] FLAGS_ONE_RESET = 19'h00000;
    localparam logic [31:0] RDATA_RESET     = 32'h00000000;

    // Phase order tracker, one-hot
    typedef enum logic [3:0] {
        SEQ_IDLE  = 4'b0001,
        SEQ_EXP_A = 4'b0010,
        SEQ_EXP_B = 4'b0100,
        SEQ_EXP_C = 4'b1000
    } mesf_seq_t;

endpackage : mesf_pkg

//--- mesf_flags.sv
/*
 * Sticky event flag bank: timeouts, phase order, fault, checksum change,
 * no-load changes, current-sum mismatch, ready events, pulse events, sign
 * changes and line swell, all write-one-to-clear over the register port.
 * Assumes event inputs are synchronous to i_clock and pulses last one cycle.
 */
//
// How it works
// (RULE_01) Missing zero crossing on phase A, B or C sets that phase's timeout flag.
// (RULE_02) Voltage crossings out of A-B-C order set the phase order fault flag.
// (RULE_03) Any recorded fault sets the summary fault flag; detail lives elsewhere.
// (RULE_04) Checksum change sets its flag and latches the new checksum result.
// (RULE_05) Any apparent-energy phase entering or leaving no-load sets its flag.
// (RULE_06) Any active-energy phase entering or leaving no-load sets its flag.
// (RULE_07) Change in current-sum RMS versus threshold relation sets mismatch flag.
// (RULE_08) Each power factor refresh, once a second, sets power factor ready.
// (RULE_09) Each full-cycle RMS refresh sets full-cycle RMS ready.
// (RULE_10) Falling edge of each pulse output sets its pulse-issued flag.
// (RULE_11) At that edge, a pulse sign differing from the last sets sign change.
// (RULE_12) On accumulator update, per-phase power sign change sets that phase's flag.
// (RULE_13) Energy ready sets every interval plus one ticks, ms or half cycles.
// (RULE_14) Line-to-line A-to-C swell condition sets its flag in word two.
// (RULE_15) Flags reset to zero, stay set; writing one clears, zero keeps.
// (RULE_16) Top bit of word two reads zero and ignores writes.
`timescale 1ns/10ps

module mesf_flags #(
    parameter int CRC_W = 32,
    parameter int SUM_W = 24,
    parameter int CNT_W = 13
) (
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    // Register port
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    input  wire logic [15:0]       i_reg_addr,
    input  wire logic [31:0]       i_reg_wdata,
    output logic      [31:0]       o_reg_rdata,
    output logic                   o_reg_rvalid,
    // Voltage zero crossing events, bit 0 phase A
    input  wire logic [2:0]        i_zx_timeout,
    input  wire logic [2:0]        i_zx_phase,
    // Fault and checksum
    input  wire logic              i_fault_event,
    input  wire logic [CRC_W-1:0]  i_checksum_value,
    output logic      [CRC_W-1:0]  o_config_checksum_result,
    // No-load levels, bit 0 phase A
    input  wire logic [2:0]        i_apparent_noload,
    input  wire logic [2:0]        i_active_noload,
    // Current sum comparison
    input  wire logic [SUM_W-1:0]  i_current_sum_rms,
    input  wire logic [SUM_W-1:0]  i_current_sum_threshold,
    // Result refresh pulses
    input  wire logic              i_power_factor_update,
    input  wire logic              i_full_cycle_rms_update,
    // Pulse output pins and their energy sign, bit 0 output one
    input  wire logic [1:0]        i_pulse_out,
    input  wire logic [1:0]        i_pulse_sign,
    // Energy interval timing
    input  wire logic [CNT_W-1:0]  i_energy_interval_count,
    input  wire logic              i_energy_interval_unit_select,
    input  wire logic              i_ms_tick,
    input  wire logic              i_half_cycle_tick,
    input  wire logic [2:0]        i_phase_power_sign,
    output logic                   o_energy_update,
    // Line swell level
    input  wire logic              i_a_to_c_line_swell,
    // Flag views
    output logic      [18:0]       o_status_one,
    output logic                   o_line_swell
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [18:0]        flags_one;
        logic               swell;
        logic               primed;
        mesf_pkg::mesf_seq_t seq;
        logic [CRC_W-1:0]   crc_prev;
        logic [CRC_W-1:0]   crc_result;
        logic [2:0]         vanl_prev;
        logic [2:0]         wnl_prev;
        logic               above_prev;
        logic [1:0]         pulse_prev;
        logic [1:0]         psign_prev;
        logic [1:0]         psign_seen;
        logic [2:0]         phsign_prev;
        logic               phsign_seen;
        logic [CNT_W-1:0]   egy_cnt;
        logic               egy_update;
        logic [31:0]        rdata;
        logic               rvalid;
    } mesf_state_t;

    mesf_state_t state_r;
    mesf_state_t state_nxt;

    // Local decode shared with the checks
    logic wr_one;
    logic wr_two;
    logic tick;
    logic above_now;
    assign wr_one    = i_reg_wr && (i_reg_addr == mesf_pkg::ADDR_STATUS_ONE);
    assign wr_two    = i_reg_wr && (i_reg_addr == mesf_pkg::ADDR_STATUS_TWO);
    assign tick      = i_energy_interval_unit_select ? i_half_cycle_tick : i_ms_tick;
    assign above_now = i_current_sum_rms > i_current_sum_threshold;

    // ************************************************************
    // Next state
    // ************************************************************
    // Events are gathered into a set vector first, so a clear and a set
    // in the same cycle resolve to set and no event is lost.
    always_comb begin
        logic [18:0] set_one;
        logic [18:0] clr_one;
        logic        falling;
        set_one   = 19'h00000;
        clr_one   = 19'h00000;
        falling   = 1'b0;
        state_nxt = state_r;
        state_nxt.primed     = 1'b1;
        state_nxt.egy_update = 1'b0;

        // Timeouts, fault and ready pulses pass straight to their flags
        set_one[mesf_pkg::BIT_TIMEOUT_LO +: 3] = i_zx_timeout;             // [RULE_01]
        set_one[mesf_pkg::BIT_FAULT]           = i_fault_event;            // [RULE_03]
        set_one[mesf_pkg::BIT_PF_READY]        = i_power_factor_update;    // [RULE_08]
        set_one[mesf_pkg::BIT_RMS_READY]       = i_full_cycle_rms_update;  // [RULE_09]

        // Phase order: after a crossing of A expect B, after B expect C
        if (i_zx_phase != 3'h0) begin
            case (state_r.seq)
                mesf_pkg::SEQ_EXP_A: set_one[mesf_pkg::BIT_PHASE_ORDER] = i_zx_phase != 3'h1;
                mesf_pkg::SEQ_EXP_B: set_one[mesf_pkg::BIT_PHASE_ORDER] = i_zx_phase != 3'h2;
                mesf_pkg::SEQ_EXP_C: set_one[mesf_pkg::BIT_PHASE_ORDER] = i_zx_phase != 3'h4;
                default:             set_one[mesf_pkg::BIT_PHASE_ORDER] = 1'b0;
            endcase // [RULE_02]
            // Resync to the crossing seen; simultaneous crossings count as out of order
            case (i_zx_phase)
                3'h1:    state_nxt.seq = mesf_pkg::SEQ_EXP_B;
                3'h2:    state_nxt.seq = mesf_pkg::SEQ_EXP_C;
                3'h4:    state_nxt.seq = mesf_pkg::SEQ_EXP_A;
                default: begin
                    state_nxt.seq = mesf_pkg::SEQ_IDLE;
                    set_one[mesf_pkg::BIT_PHASE_ORDER] = 1'b1; // [RULE_02]
                end
            endcase
        end

        // Change detectors; the first cycle after reset only primes them
        state_nxt.crc_prev   = i_checksum_value;
        state_nxt.vanl_prev  = i_apparent_noload;
        state_nxt.wnl_prev   = i_active_noload;
        state_nxt.above_prev = above_now;
        if (state_r.primed) begin
            if (i_checksum_value != state_r.crc_prev) begin
                set_one[mesf_pkg::BIT_CHECKSUM_CHG] = 1'b1;                // [RULE_04]
                state_nxt.crc_result = i_checksum_value;                   // [RULE_04]
            end
            set_one[mesf_pkg::BIT_APPAR_NOLOAD]  = |(i_apparent_noload ^ state_r.vanl_prev); // [RULE_05]
            set_one[mesf_pkg::BIT_ACTIVE_NOLOAD] = |(i_active_noload ^ state_r.wnl_prev);    // [RULE_06]
            set_one[mesf_pkg::BIT_SUM_MISMATCH]  = above_now != state_r.above_prev;          // [RULE_07]
        end else begin
            state_nxt.crc_result = i_checksum_value;
        end

        // Pulse outputs: act on the high-to-low edge of each pin
        state_nxt.pulse_prev = i_pulse_out;
        for (int i = 0; i < 2; i++) begin
            falling = state_r.pulse_prev[i] && !i_pulse_out[i];
            if (falling) begin
                set_one[mesf_pkg::BIT_PULSE_DONE_LO + i] = 1'b1;           // [RULE_10]
                set_one[mesf_pkg::BIT_PULSE_SIGN_LO + i] =
                    state_r.psign_seen[i] && (state_r.psign_prev[i] != i_pulse_sign[i]); // [RULE_11]
                state_nxt.psign_prev[i] = i_pulse_sign[i];
                state_nxt.psign_seen[i] = 1'b1;
            end
        end

        // Energy interval: update after interval plus one ticks
        if (tick) begin
            if (state_r.egy_cnt >= i_energy_interval_count) begin
                state_nxt.egy_cnt    = '0;
                state_nxt.egy_update = 1'b1;
                set_one[mesf_pkg::BIT_ENERGY_READY] = 1'b1;                // [RULE_13]
                // Power sign is judged only when the accumulators refresh
                if (state_r.phsign_seen) begin
                    set_one[mesf_pkg::BIT_PHASE_SIGN_LO +: 3] =
                        i_phase_power_sign ^ state_r.phsign_prev;          // [RULE_12]
                end
                state_nxt.phsign_prev = i_phase_power_sign;
                state_nxt.phsign_seen = 1'b1;
            end else begin
                state_nxt.egy_cnt = CNT_W'(state_r.egy_cnt + 1'b1);
            end
        end

        // Write-one-to-clear, set wins over clear
        if (wr_one) begin
            clr_one = i_reg_wdata[18:0];
        end
        state_nxt.flags_one = (state_r.flags_one & ~clr_one) | set_one;   // [RULE_15]
        state_nxt.swell = (state_r.swell && !(wr_two && i_reg_wdata[mesf_pkg::BIT_AC_SWELL]))
                          || i_a_to_c_line_swell;                         // [RULE_14]

        // Reads answer one cycle later; unmapped addresses read zero
        state_nxt.rvalid = i_reg_rd;
        state_nxt.rdata  = mesf_pkg::RDATA_RESET;
        if (i_reg_rd && (i_reg_addr == mesf_pkg::ADDR_STATUS_ONE)) begin
            state_nxt.rdata[18:0] = state_r.flags_one;
        end else if (i_reg_rd && (i_reg_addr == mesf_pkg::ADDR_STATUS_TWO)) begin
            // Reserved top bit stays at zero whatever was written
            state_nxt.rdata[mesf_pkg::BIT_AC_SWELL] = state_r.swell;      // [RULE_16]
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Every field is reset so flags come up clear
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_r             <= '0;
            state_r.flags_one   <= mesf_pkg::FLAGS_ONE_RESET;             // [RULE_15]
            state_r.seq         <= mesf_pkg::SEQ_IDLE;
            state_r.rdata       <= mesf_pkg::RDATA_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign o_reg_rdata              = state_r.rdata;
    assign o_reg_rvalid             = state_r.rvalid;
    assign o_config_checksum_result = state_r.crc_result;
    assign o_energy_update          = state_r.egy_update;
    assign o_status_one             = state_r.flags_one;
    assign o_line_swell             = state_r.swell;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking mesf_cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    AST_TIMEOUT_SET: assert property (i_zx_timeout[2] |=> o_status_one[18]) // [RULE_01]
        else $error("phase C timeout did not set its flag");
    AST_ORDER_FAULT: assert property ((state_r.seq == mesf_pkg::SEQ_EXP_A && i_zx_phase == 3'h2)
        |=> o_status_one[15] && state_r.seq == mesf_pkg::SEQ_EXP_C) // [RULE_02]
        else $error("out of order crossing not flagged");
    AST_FAULT_SET: assert property (i_fault_event |=> o_status_one[14]) // [RULE_03]
        else $error("fault event lost");
    AST_CHECKSUM: assert property ((state_r.primed && i_checksum_value != state_r.crc_prev)
        |=> o_status_one[13] && o_config_checksum_result == $past(i_checksum_value)) // [RULE_04]
        else $error("checksum change not recorded");
    AST_APPAR_NOLOAD: assert property ((state_r.primed && $changed(i_apparent_noload))
        |=> o_status_one[12]) // [RULE_05]
        else $error("apparent no-load change missed");
    AST_ACTIVE_NOLOAD: assert property ((state_r.primed && $changed(i_active_noload))
        |=> o_status_one[11]) // [RULE_06]
        else $error("active no-load change missed");
    AST_SUM_MISMATCH: assert property ((state_r.primed && above_now != state_r.above_prev)
        |=> o_status_one[10]) // [RULE_07]
        else $error("current sum relation change missed");
    AST_PF_READY: assert property (i_power_factor_update |=> o_status_one[9]) // [RULE_08]
        else $error("power factor ready not set");
    AST_RMS_READY: assert property (i_full_cycle_rms_update |=> o_status_one[8]) // [RULE_09]
        else $error("full cycle rms ready not set");
    AST_PULSE_DONE: assert property ((state_r.pulse_prev[1] && !i_pulse_out[1])
        |=> o_status_one[7]) // [RULE_10]
        else $error("pulse two falling edge not flagged");
    AST_PULSE_SIGN: assert property ((state_r.pulse_prev[0] && !i_pulse_out[0]
        && state_r.psign_seen[0] && state_r.psign_prev[0] != i_pulse_sign[0])
        |=> o_status_one[4]) // [RULE_11]
        else $error("pulse one sign change not flagged");
    AST_PHASE_SIGN: assert property ((tick && state_r.egy_cnt >= i_energy_interval_count
        && state_r.phsign_seen && i_phase_power_sign[0] != state_r.phsign_prev[0])
        |=> o_status_one[1]) // [RULE_12]
        else $error("phase A sign change not flagged");
    AST_ENERGY_READY: assert property ((tick && state_r.egy_cnt >= i_energy_interval_count)
        |=> o_energy_update && o_status_one[0] && state_r.egy_cnt == '0) // [RULE_13]
        else $error("energy update not issued at interval end");
    AST_SWELL: assert property (i_a_to_c_line_swell |=> o_line_swell) // [RULE_14]
        else $error("line swell not flagged");
    AST_W1C_CLEAR: assert property ((wr_one && i_reg_wdata[9] && !i_power_factor_update)
        |=> !o_status_one[9]) // [RULE_15]
        else $error("write one did not clear flag");
    AST_W0_KEEP: assert property ((o_status_one[14] && wr_one && !i_reg_wdata[14])
        |=> o_status_one[14]) // [RULE_15]
        else $error("write zero disturbed flag");
    AST_RESERVED: assert property (i_reg_rd |=> o_reg_rvalid && !o_reg_rdata[31]) // [RULE_16]
        else $error("reserved bit read as one");

    COV_ORDER_FAULT: cover property (o_status_one[15] && o_reg_rvalid);
    COV_CLEAR_RACE: cover property (wr_one && i_reg_wdata[14] && i_fault_event);
    COV_ENERGY: cover property (o_energy_update ##1 wr_one ##1 !o_status_one[0]);

endmodule : mesf_flags

//--- mesf_host.sv
/*
 * Host model of the flag bank's register port: one-cycle write and read
 * strobes, launched just after a falling edge and held over one rising edge.
 * Assumes the bench calls wr and rd and drives every other input itself.
 */
`timescale 1ns/10ps

module mesf_host (
    // Clock
    input  wire logic        i_clock,
    // Register port, host side
    output logic             o_reg_wr,
    output logic             o_reg_rd,
    output logic [15:0]      o_reg_addr,
    output logic [31:0]      o_reg_wdata,
    input  wire logic [31:0] i_reg_rdata,
    input  wire logic        i_reg_rvalid
);
    // ************************************************************
    // Bus cycles
    // ************************************************************
    // Idle strobes low from time zero
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_addr  = 16'h0000;
        o_reg_wdata = 32'h00000000;
    end

    // Ones clear flags, zeros keep them
    task wr(input logic [15:0] addr, input logic [31:0] data);
        @(negedge i_clock);
        o_reg_wr    = 1'b1;
        o_reg_addr  = addr;
        o_reg_wdata = data;
        @(negedge i_clock);
        o_reg_wr    = 1'b0;
        o_reg_addr  = ~addr;    // Released bus shows junk, not the last value
        o_reg_wdata = ~data;
    endtask : wr

    // Answer expected one cycle after the strobe; bounded wait for it
    task rd(input logic [15:0] addr, output logic [31:0] data, output logic ok);
        ok   = 1'b0;
        data = 32'h00000000;
        @(negedge i_clock);
        o_reg_rd   = 1'b1;
        o_reg_addr = addr;
        @(negedge i_clock);
        o_reg_rd   = 1'b0;
        o_reg_addr = ~addr;
        // The answer stands only in the cycle after the strobe, so look before waiting
        for (int i = 0; i < 4 && !ok; i++) begin
            if (i_reg_rvalid === 1'b1) begin
                ok   = 1'b1;
                data = i_reg_rdata;
            end else begin
                @(negedge i_clock);
            end
        end
    endtask : rd
endmodule : mesf_host

//--- metering_event_status_flags_test.sv
/*
 * Self-checking bench of the flag bank: raises each event, reads the flags
 * through the host model and clears them by writing ones.
 * Assumes the host model owns the register port and that inputs change at falling edges.
 */
`timescale 1ns/10ps

module metering_event_status_flags_test;
    localparam logic [15:0] W1 = mesf_pkg::ADDR_STATUS_ONE;
    localparam logic [15:0] W2 = mesf_pkg::ADDR_STATUS_TWO;

    // ************************************************************
    // Signals
    // ************************************************************
    logic        i_clock, i_reset, fault, pf, rms_up, ms, half, unit, swell;
    logic [2:0]  zx_to, zx_ph, app_nl, act_nl, ph_sign;
    logic [1:0]  pout, psign;
    logic [31:0] cks;
    logic [23:0] sum_rms, sum_thr;
    logic [12:0] n_cnt;
    logic        reg_wr, reg_rd, rvalid, egy_upd, line_swell;
    logic [15:0] reg_addr;
    logic [31:0] wdata, rdata, cks_res;
    logic [18:0] status_one;
    int          fails, check_count;

    // Clock, 4 ns period
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    mesf_host host (.i_clock(i_clock), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(wdata), .i_reg_rdata(rdata),
        .i_reg_rvalid(rvalid));

    mesf_flags #(.CRC_W(32), .SUM_W(24), .CNT_W(13)) dut (
        .i_clock(i_clock), .i_reset(i_reset), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_zx_timeout(zx_to), .i_zx_phase(zx_ph),
        .i_fault_event(fault), .i_checksum_value(cks), .o_config_checksum_result(cks_res),
        .i_apparent_noload(app_nl), .i_active_noload(act_nl),
        .i_current_sum_rms(sum_rms), .i_current_sum_threshold(sum_thr),
        .i_power_factor_update(pf), .i_full_cycle_rms_update(rms_up),
        .i_pulse_out(pout), .i_pulse_sign(psign), .i_energy_interval_count(n_cnt),
        .i_energy_interval_unit_select(unit), .i_ms_tick(ms), .i_half_cycle_tick(half),
        .i_phase_power_sign(ph_sign), .o_energy_update(egy_upd),
        .i_a_to_c_line_swell(swell), .o_status_one(status_one), .o_line_swell(line_swell));

    // ************************************************************
    // Helpers
    // ************************************************************
    task final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task read_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        host.rd(a, d, ok);
        if (!ok) begin
            fails++;
            $display("FAIL at %0t: no read answer", $time);
            final_report();
        end
        check(d, exp);
    endtask : read_chk

    // Read word one, show that zeros keep and ones clear
    task drain(input logic [31:0] exp);
        read_chk(W1, exp);
        check({13'h0, status_one}, exp);
        host.wr(W1, 32'h00000000);
        read_chk(W1, exp);
        host.wr(W1, 32'hffffffff);
        read_chk(W1, 32'h00000000);
    endtask : drain

    // One-cycle pulse on event input k
    task fire(input int k, input logic [2:0] v);
        @(negedge i_clock);
        case (k)
            0: zx_to = v;
            1: zx_ph = v;
            2: fault = v[0];
            3: pf = v[0];
            4: rms_up = v[0];
            5: ms = v[0];
            default: half = v[0];
        endcase
        @(negedge i_clock);
        {zx_to, zx_ph, fault, pf, rms_up, ms, half} = '0;
    endtask : fire

    // Pulse output o high then low; sign held over the falling edge
    task cf(input int o, input logic s);
        @(negedge i_clock);
        pout[o]  = 1'b1;
        psign[o] = s;
        @(negedge i_clock);
        pout[o] = 1'b0;
        @(negedge i_clock);
    endtask : cf

    // Bounded wait for the energy update pulse
    task wait_update();
        for (int i = 0; i < 6; i++) begin
            if (egy_upd === 1'b1) begin
                check(32'(i), 32'h0);
                return;
            end
            @(negedge i_clock);
        end
        fails++;
        $display("FAIL at %0t: energy update missing", $time);
        final_report();
    endtask : wait_update

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {i_reset, zx_to, zx_ph, fault, pf, rms_up, ms, half, unit, swell} = '1;
        {zx_to, zx_ph, fault, pf, rms_up, ms, half, unit, swell} = '0;
        {app_nl, act_nl, ph_sign, pout, psign} = '0;
        cks     = 32'h12345678;
        sum_rms = 24'h000000;
        sum_thr = 24'h000010;
        n_cnt   = 13'h0001;
        fails       = 0;
        check_count = 0;
        repeat (12) @(negedge i_clock);
        i_reset = 1'b0;
        read_chk(W1, 32'h0);
        read_chk(W2, 32'h0);
        read_chk(16'h0403, 32'h0);
        check(cks_res, 32'h12345678);
        for (int b = 0; b < 3; b++) begin
            fire(0, 3'b001 << b);
            drain(32'h1 << (16 + b));
        end
        // Correct order after the syncing crossing, then A skipped
        fire(1, 3'b001);
        fire(1, 3'b010);
        fire(1, 3'b100);
        fire(1, 3'b001);
        fire(1, 3'b010);
        fire(1, 3'b100);
        drain(32'h0);
        fire(1, 3'b010);
        drain(32'h8000);
        // Two crossings in one cycle count as out of order
        fire(1, 3'b011);
        drain(32'h8000);
        fire(2, 3'b001);
        host.wr(16'h0403, 32'hffffffff);     // Unmapped write must not clear
        drain(32'h4000);
        fire(3, 3'b001);
        drain(32'h200);
        fire(4, 3'b001);
        drain(32'h100);
        @(negedge i_clock);
        cks = 32'h0badf00d;
        drain(32'h2000);
        check(cks_res, 32'h0badf00d);
        app_nl = 3'b100;
        drain(32'h1000);
        act_nl = 3'b010;
        drain(32'h800);
        act_nl = 3'b000;
        drain(32'h800);
        sum_rms = 24'h000020;
        drain(32'h400);
        cf(0, 1'b0);
        drain(32'h40);
        cf(0, 1'b1);
        drain(32'h50);
        cf(1, 1'b0);
        drain(32'h80);
        cf(1, 1'b1);
        drain(32'ha0);
        cf(1, 1'b1);
        drain(32'h80);
        // Interval one needs two millisecond ticks
        fire(5, 3'b001);
        read_chk(W1, 32'h0);
        fire(5, 3'b001);
        wait_update();
        drain(32'h1);
        ph_sign = 3'b010;
        fire(5, 3'b001);
        fire(5, 3'b001);
        wait_update();
        drain(32'h5);
        // Half-cycle mode ignores millisecond ticks
        unit    = 1'b1;
        ph_sign = 3'b011;
        fire(5, 3'b001);
        fire(5, 3'b001);
        read_chk(W1, 32'h0);
        fire(6, 3'b001);
        fire(6, 3'b001);
        wait_update();
        drain(32'h3);
        swell = 1'b1;
        read_chk(W2, 32'h40000000);
        check({31'h0, line_swell}, 32'h1);
        host.wr(W2, 32'hffffffff);
        read_chk(W2, 32'h40000000);
        swell = 1'b0;
        host.wr(W2, 32'hffffffff);
        read_chk(W2, 32'h0);
        check({31'h0, line_swell}, 32'h0);
        final_report();
    end
endmodule : metering_event_status_flags_test
